// ==== core/asf_flags.sv ====
`timescale 1ns/1ps
`default_nettype none

module asf_flags
    import asf_pkg::*;
#(
    parameter int TEMP_W = 16,
    parameter int ROT_W = 12
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire asf_status_cond_type status_cond,
    input wire asf_event_cond_type event_cond,
    input wire asf_packet_cond_type packet_cond,
    input wire asf_flag_mask_type flag_mask,
    input wire logic [11:0] angle_value,
    input wire logic signed [TEMP_W-1:0] temp_raw,
    input wire logic [11:0] field_gauss,
    input wire logic [11:0] mag_thres_lo,
    input wire logic [11:0] mag_thres_hi,
    input wire logic signed [11:0] turn_count,
    input wire logic signed [ROT_W-1:0] turn_rotations,
    input wire logic signed [15:0] turn_delta,
    input wire logic turn_source_pll,
    input wire logic rd_stb,
    input wire logic [7:0] rd_addr,
    input wire logic clr_fault,
    input wire logic clr_caution,
    input wire logic clr_status,
    output logic [15:0] rd_data_r,
    output logic rd_valid_r,
    output logic packet_discard_r,
    output logic undervoltage_flag_r,
    output logic summary_fault_flag_r
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (TEMP_W < 12 || TEMP_W > 16)
    begin : g_bad_temp_w
        $error("asf_flags: TEMP_W must be 12 to 16");
    end
    if (ROT_W < 10 || ROT_W > 16)
    begin : g_bad_rot_w
        $error("asf_flags: ROT_W must be 10 to 16");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] fault_r;
    logic [15:0] fault_nxt;
    logic [15:0] fault_seen_r;
    logic [15:0] caution_r;
    logic [15:0] caution_nxt;
    logic [15:0] caution_seen_r;
    logic boot_done_r;
    logic special_done_r;
    logic signed [11:0] temp_r;
    logic [15:0] fault_set;
    logic [15:0] caution_set;
    logic [15:0] fault_word;
    logic [15:0] angle_word;
    logic [15:0] status_word;
    logic [15:0] turns_word;
    logic [15:0] rd_word;
    logic uv_live;
    logic ef_live;
    logic caution_live;
    logic signed [15:0] temp_ext;
    logic signed [15:0] rot_ext;
    logic signed [15:0] delta_abs;
    logic temp_low;
    logic temp_high;

    // word with bit 12 chosen for odd parity over 16 bits
    function automatic logic [15:0] asf_odd_word(input logic [15:0] w);
        logic [15:0] t;
        t = w;
        t[ASF_POS_PARITY] = 1'b0;
        t[ASF_POS_PARITY] = ~(^t);
        return t;
    endfunction

    // ------------------------------------------------------------
    // live summary terms
    // ------------------------------------------------------------
    // masked OR of both undervoltage detectors
    assign uv_live = (event_cond.analog_undervolt & ~flag_mask.analog_uv_mask)
        | (event_cond.digital_undervolt & ~flag_mask.digital_uv_mask);
    // any unmasked caution; its fault mask bit hides it in the fault word but not in the summary
    assign caution_live = |(caution_r & ~flag_mask.caution_mask);
    assign fault_word = {fault_r[15:ASF_FLT_WAR+1],
        caution_live & ~flag_mask.fault_mask[ASF_FLT_WAR],
        fault_r[ASF_FLT_WAR-1:0]};
    assign ef_live = (|(fault_word & ~flag_mask.fault_mask))
        | caution_live;

    // ------------------------------------------------------------
    // range comparisons
    // ------------------------------------------------------------
    assign temp_ext = 16'(temp_raw);
    assign rot_ext = 16'(turn_rotations);
    assign delta_abs = turn_delta[15] ? -turn_delta : turn_delta;
    assign temp_low = temp_ext < ASF_TEMP_MIN;
    assign temp_high = temp_ext > ASF_TEMP_MAX;

    // ------------------------------------------------------------
    // set terms of the fault latch
    // ------------------------------------------------------------
    // a level condition sets again every cycle it persists
    always_comb
    begin
        fault_set = ASF_ZERO_WORD;
        fault_set[ASF_FLT_RST] = event_cond.hard_reset;
        fault_set[ASF_FLT_FLOW] = field_gauss < mag_thres_lo;
        fault_set[ASF_FLT_UVA] = event_cond.analog_undervolt;
        fault_set[ASF_FLT_UVD] = event_cond.digital_undervolt;
        fault_set[ASF_FLT_OSC] = event_cond.osc_watchdog_trip;
        fault_set[ASF_FLT_ECCU] = event_cond.ecc_uncorrectable;
        fault_set[ASF_FLT_ZCT] = event_cond.zero_cross_timeout;
        fault_set[ASF_FLT_LOCK] = event_cond.lock_lost;
        fault_set[ASF_FLT_QUAD] = event_cond.quadrature_fault;
        fault_set[ASF_FLT_AVG] = event_cond.averaging_fault;
        fault_set[ASF_FLT_STF] = event_cond.selftest_fail;
    end

    // ------------------------------------------------------------
    // set terms of the caution latch
    // ------------------------------------------------------------
    always_comb
    begin
        caution_set = ASF_ZERO_WORD;
        caution_set[ASF_CAU_TOV] = (rot_ext > ASF_TURN_LIMIT)
            | (rot_ext < -ASF_TURN_LIMIT);
        caution_set[ASF_CAU_FHI] = field_gauss > mag_thres_hi;
        caution_set[ASF_CAU_BSY] = event_cond.access_collision;
        caution_set[ASF_CAU_TDW] = delta_abs > ASF_DELTA_LIMIT;
        caution_set[ASF_CAU_SAT] = event_cond.saturation;
        caution_set[ASF_CAU_ECCC] = event_cond.ecc_corrected;
        caution_set[ASF_CAU_TR] = temp_low | temp_high;
        caution_set[ASF_CAU_XEE] = event_cond.command_exec_fail;
        caution_set[ASF_CAU_SLEW] = event_cond.slew_limit;
        caution_set[ASF_CAU_CRC] = packet_cond.crc_error;
        caution_set[ASF_CAU_IER] = packet_cond.bit_count_error
            | packet_cond.input_bit15;
    end

    // ------------------------------------------------------------
    // next values: clear only the bits seen, then set wins
    // ------------------------------------------------------------
    always_comb
    begin
        fault_nxt = fault_r;
        if (clr_fault)
        begin
            fault_nxt = fault_r & ~fault_seen_r;
        end
        fault_nxt = (fault_nxt | fault_set) & ASF_FAULT_LATCH_MASK;
    end

    always_comb
    begin
        caution_nxt = caution_r;
        if (clr_caution)
        begin
            caution_nxt = caution_r & ~caution_seen_r;
        end
        caution_nxt = (caution_nxt | caution_set)
            & ASF_CAUTION_LATCH_MASK;
    end

    // ------------------------------------------------------------
    // sticky fault latch; reset itself marks the reset flag
    // ------------------------------------------------------------
    // logic self-test is not an input here, so it cannot set it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fault_r <= ASF_FAULT_RESET;
        end
        else
        begin
            fault_r <= fault_nxt;
        end
    end

    // ------------------------------------------------------------
    // sticky caution latch
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            caution_r <= ASF_CAUTION_RESET;
        end
        else
        begin
            caution_r <= caution_nxt;
        end
    end

    // ------------------------------------------------------------
    // record of bits the host has read
    // ------------------------------------------------------------
    // a clear consumes the record; a read in the same cycle refills it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fault_seen_r <= ASF_ZERO_WORD;
            caution_seen_r <= ASF_ZERO_WORD;
        end
        else
        begin
            if (rd_stb && rd_addr == ASF_OFS_FAULT)
            begin
                fault_seen_r <= fault_r;
            end
            else if (clr_fault)
            begin
                fault_seen_r <= ASF_ZERO_WORD;
            end
            if (rd_stb && rd_addr == ASF_OFS_CAUTION)
            begin
                caution_seen_r <= caution_r;
            end
            else if (clr_caution)
            begin
                caution_seen_r <= ASF_ZERO_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // boot and special action completion
    // ------------------------------------------------------------
    // completion wins over a status clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            boot_done_r <= 1'b0;
            special_done_r <= 1'b0;
        end
        else
        begin
            if (status_cond.nvm_loaded && status_cond.selftests_done)
            begin
                boot_done_r <= 1'b1;
            end
            else if (clr_status)
            begin
                boot_done_r <= 1'b0;
            end
            if (status_cond.special_done)
            begin
                special_done_r <= 1'b1;
            end
            else if (status_cond.special_trigger || clr_status)
            begin
                special_done_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // clamped temperature
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            temp_r <= 12'sh000;
        end
        else if (temp_low)
        begin
            temp_r <= ASF_TEMP_MIN[11:0];
        end
        else if (temp_high)
        begin
            temp_r <= ASF_TEMP_MAX[11:0];
        end
        else
        begin
            temp_r <= temp_ext[11:0];
        end
    end

    // ------------------------------------------------------------
    // output word assembly
    // ------------------------------------------------------------
    always_comb
    begin
        angle_word = {4'h0, angle_value};
        angle_word[ASF_POS_UV] = uv_live;
        angle_word[ASF_POS_EF] = ef_live;
        angle_word = asf_odd_word(angle_word);
        status_word = ASF_ZERO_WORD;
        status_word[ASF_STA_AOK] = status_cond.angle_valid;
        status_word[ASF_STA_BOOT] = status_cond.boot_active;
        status_word[ASF_STA_XTEST] = status_cond.transducer_test_running;
        status_word[ASF_STA_LTEST] = status_cond.logic_selftest_running;
        status_word[ASF_STA_BDONE] = boot_done_r;
        status_word[ASF_STA_SDONE] = special_done_r;
        status_word[ASF_STA_LPBLK] = status_cond.low_power_blocked;
        status_word[ASF_STA_DIR] = status_cond.direction_falling;
        status_word[ASF_STA_DIE+:2] = status_cond.die_index;
        turns_word = {4'h0, turn_count};
        turns_word[ASF_POS_TSRC] = turn_source_pll;
        turns_word = asf_odd_word(turns_word);
    end

    // ------------------------------------------------------------
    // read multiplexer; unknown offsets read as zero
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (rd_addr)
            ASF_OFS_ANGLE: rd_word = angle_word;
            ASF_OFS_STATUS: rd_word = status_word;
            ASF_OFS_FAULT: rd_word = fault_word;
            ASF_OFS_CAUTION: rd_word = caution_r;
            ASF_OFS_TEMP: rd_word = {4'h0, temp_r};
            ASF_OFS_FIELD: rd_word = {4'h0, field_gauss};
            ASF_OFS_TURNS: rd_word = turns_word;
            default: rd_word = ASF_ZERO_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // registered read answer, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rd_data_r <= ASF_ZERO_WORD;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= rd_stb;
            if (rd_stb)
            begin
                rd_data_r <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // packet discard and live summary outputs
    // ------------------------------------------------------------
    // the serial front end must drop the packet on this pulse
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            packet_discard_r <= 1'b0;
            undervoltage_flag_r <= 1'b0;
            summary_fault_flag_r <= 1'b0;
        end
        else
        begin
            packet_discard_r <= packet_cond.crc_error
                | packet_cond.bit_count_error
                | packet_cond.input_bit15;
            undervoltage_flag_r <= uv_live;
            summary_fault_flag_r <= ef_live;
        end
    end

endmodule

`default_nettype wire

// ==== core/asf_pkg.sv ====
package asf_pkg;

    // ------------------------------------------------------------
    // register offsets on the primary serial interface
    // ------------------------------------------------------------
    localparam logic [7:0] ASF_OFS_ANGLE = 8'h20;
    localparam logic [7:0] ASF_OFS_STATUS = 8'h22;
    localparam logic [7:0] ASF_OFS_FAULT = 8'h24;
    localparam logic [7:0] ASF_OFS_CAUTION = 8'h26;
    localparam logic [7:0] ASF_OFS_TEMP = 8'h28;
    localparam logic [7:0] ASF_OFS_FIELD = 8'h2A;
    localparam logic [7:0] ASF_OFS_TURNS = 8'h2C;

    // ------------------------------------------------------------
    // shared field positions of the output words
    // ------------------------------------------------------------
    localparam int ASF_POS_PARITY = 12;
    localparam int ASF_POS_UV = 13;
    localparam int ASF_POS_EF = 14;
    localparam int ASF_POS_TSRC = 13;

    // ------------------------------------------------------------
    // status word positions
    // ------------------------------------------------------------
    localparam int ASF_STA_AOK = 0;
    localparam int ASF_STA_BOOT = 1;
    localparam int ASF_STA_XTEST = 2;
    localparam int ASF_STA_LTEST = 3;
    localparam int ASF_STA_BDONE = 4;
    localparam int ASF_STA_SDONE = 5;
    localparam int ASF_STA_LPBLK = 6;
    localparam int ASF_STA_DIR = 7;
    localparam int ASF_STA_DIE = 8;

    // ------------------------------------------------------------
    // fault latch positions
    // ------------------------------------------------------------
    localparam int ASF_FLT_RST = 0;
    localparam int ASF_FLT_FLOW = 1;
    localparam int ASF_FLT_UVA = 2;
    localparam int ASF_FLT_UVD = 3;
    localparam int ASF_FLT_OSC = 4;
    localparam int ASF_FLT_ECCU = 5;
    localparam int ASF_FLT_ZCT = 6;
    localparam int ASF_FLT_LOCK = 7;
    localparam int ASF_FLT_QUAD = 8;
    localparam int ASF_FLT_AVG = 9;
    localparam int ASF_FLT_STF = 10;
    localparam int ASF_FLT_WAR = 11;

    // ------------------------------------------------------------
    // caution latch positions
    // ------------------------------------------------------------
    localparam int ASF_CAU_TOV = 0;
    localparam int ASF_CAU_FHI = 1;
    localparam int ASF_CAU_BSY = 2;
    localparam int ASF_CAU_TDW = 3;
    localparam int ASF_CAU_SAT = 4;
    localparam int ASF_CAU_ECCC = 5;
    localparam int ASF_CAU_TR = 6;
    localparam int ASF_CAU_XEE = 7;
    localparam int ASF_CAU_SLEW = 8;
    localparam int ASF_CAU_CRC = 10;
    localparam int ASF_CAU_IER = 11;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] ASF_FAULT_RESET = 16'h0001;
    localparam logic [15:0] ASF_CAUTION_RESET = 16'h0000;
    localparam logic [15:0] ASF_ZERO_WORD = 16'h0000;
    // latched bits only; fault bit 11 is live
    localparam logic [15:0] ASF_FAULT_LATCH_MASK = 16'h07FF;
    localparam logic [15:0] ASF_CAUTION_LATCH_MASK = 16'h0DFF;
    // temperature in eighths relative to 25 C: -60 C and 180 C
    localparam logic signed [15:0] ASF_TEMP_MIN = -16'sd680;
    localparam logic signed [15:0] ASF_TEMP_MAX = 16'sd1240;
    // full rotations allowed in either direction
    localparam logic signed [15:0] ASF_TURN_LIMIT = 16'sd256;
    // 135 degrees in 4096-per-turn angle units
    localparam logic signed [15:0] ASF_DELTA_LIMIT = 16'sd1536;

    // ------------------------------------------------------------
    // condition carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic angle_valid;
        logic boot_active;
        logic transducer_test_running;
        logic logic_selftest_running;
        logic nvm_loaded;
        logic selftests_done;
        logic special_trigger;
        logic special_done;
        logic low_power_blocked;
        logic direction_falling;
        logic [1:0] die_index;
    } asf_status_cond_type;

    typedef struct packed {
        logic hard_reset;
        logic analog_undervolt;
        logic digital_undervolt;
        logic osc_watchdog_trip;
        logic ecc_uncorrectable;
        logic ecc_corrected;
        logic zero_cross_timeout;
        logic lock_lost;
        logic quadrature_fault;
        logic averaging_fault;
        logic selftest_fail;
        logic access_collision;
        logic saturation;
        logic command_exec_fail;
        logic slew_limit;
    } asf_event_cond_type;

    typedef struct packed {
        logic crc_error;
        logic bit_count_error;
        logic input_bit15;
    } asf_packet_cond_type;

    typedef struct packed {
        logic analog_uv_mask;
        logic digital_uv_mask;
        logic [15:0] fault_mask;
        logic [15:0] caution_mask;
    } asf_flag_mask_type;

endpackage

// ==== tb/asf_flags_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module asf_chk
    import asf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire asf_status_cond_type status_cond,
    input wire asf_event_cond_type event_cond,
    input wire asf_packet_cond_type packet_cond,
    input wire asf_flag_mask_type flag_mask,
    input wire logic [11:0] angle_value,
    input wire logic [11:0] field_gauss,
    input wire logic rd_stb,
    input wire logic [7:0] rd_addr,
    input wire logic [15:0] rd_data_r,
    input wire logic rd_valid_r,
    input wire logic packet_discard_r,
    input wire logic undervoltage_flag_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // masked live undervoltage
    logic uv_in;
    assign uv_in = (event_cond.analog_undervolt & ~flag_mask.analog_uv_mask)
        | (event_cond.digital_undervolt & ~flag_mask.digital_uv_mask);
    // event then a read of its register
    sequence s_uva_rd;
        event_cond.analog_undervolt ##1 (rd_stb && rd_addr == ASF_OFS_FAULT);
    endsequence
    sequence s_crc_rd;
        packet_cond.crc_error ##[1:8] (rd_stb && rd_addr == ASF_OFS_CAUTION);
    endsequence
    AST_RD_ANSWER: assert property (rd_stb |=> rd_valid_r)
        else $error("read strobe got no valid");
    AST_UV_LIVE: assert property (
        1'b1 |=> undervoltage_flag_r == $past(uv_in))
        else $error("undervoltage flag wrong");
    AST_PKT_DROP: assert property ((|packet_cond) |=> packet_discard_r)
        else $error("bad packet not dropped");
    AST_FIELD_WORD: assert property (
        rd_stb && rd_addr == ASF_OFS_FIELD
        |=> rd_data_r == {4'h0, $past(field_gauss)})
        else $error("field word wrong");
    AST_STATUS_WORD: assert property (
        rd_stb && rd_addr == ASF_OFS_STATUS
        |=> {rd_data_r[9:6], rd_data_r[3:0]} == $past({status_cond.die_index,
        status_cond.direction_falling, status_cond.low_power_blocked,
        status_cond.logic_selftest_running,
        status_cond.transducer_test_running, status_cond.boot_active,
        status_cond.angle_valid}))
        else $error("status word wrong");
    AST_ANGLE_WORD: assert property (
        rd_stb && rd_addr == ASF_OFS_ANGLE
        |=> ^rd_data_r && rd_data_r[11:0] == $past(angle_value)
        && rd_data_r[13] == $past(uv_in))
        else $error("angle word wrong");
    AST_UV_STICKY: assert property (s_uva_rd |=> rd_data_r[ASF_FLT_UVA])
        else $error("undervoltage fault not latched");
    AST_CRC_LATCH: assert property (s_crc_rd |=> rd_data_r[ASF_CAU_CRC])
        else $error("checksum caution not latched");
endmodule
bind asf_flags asf_chk chk_u (.clk_sys(clk_sys), .reset(reset),
    .status_cond(status_cond), .event_cond(event_cond),
    .packet_cond(packet_cond), .flag_mask(flag_mask),
    .angle_value(angle_value), .field_gauss(field_gauss), .rd_stb(rd_stb),
    .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .packet_discard_r(packet_discard_r),
    .undervoltage_flag_r(undervoltage_flag_r));
`default_nettype wire

// ==== tb/asf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module asf_host_model
    import asf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic req,
    input wire logic [7:0] req_addr,
    output logic rd_stb,
    output logic [7:0] rd_addr
);
    // one strobe per request; host reads before it clears
    always_ff @(posedge clk_sys)
    begin
        rd_stb <= req;
        rd_addr <= req_addr;
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import asf_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    asf_status_cond_type st = '0;
    asf_event_cond_type ev = '0;
    asf_packet_cond_type pk = '0;
    asf_flag_mask_type fm = '0;
    logic [11:0] ang = '0, gs = 12'h100;
    logic signed [11:0] tc = '0, rot = '0;
    logic signed [15:0] tr = '0, td = '0;
    logic tsrc = 1'b0, req = 1'b0, cf = 1'b0, cc = 1'b0, cs = 1'b0;
    logic [7:0] ra = '0, addr;
    logic [15:0] rdat, e;
    logic stb, vld, sff;
    logic [15:0] q[$];
    int n_fail = 0, num_checks = 0, cyc = 0;
    // caution flag and bit position per event bit, lsb first
    logic [4:0] map [15] = '{5'h18, 5'h17, 5'h14, 5'h12, 5'h0A, 5'h09,
        5'h08, 5'h07, 5'h06, 5'h15, 5'h05, 5'h04, 5'h03, 5'h02, 5'h00};
    asf_flags dut_u (.clk_sys(clk_sys), .reset(reset), .status_cond(st),
        .event_cond(ev), .packet_cond(pk), .flag_mask(fm), .angle_value(ang),
        .temp_raw(tr), .field_gauss(gs), .mag_thres_lo(12'h010),
        .mag_thres_hi(12'hF00), .turn_count(tc), .turn_rotations(rot),
        .turn_delta(td), .turn_source_pll(tsrc), .rd_stb(stb), .rd_addr(addr),
        .clr_fault(cf), .clr_caution(cc), .clr_status(cs), .rd_data_r(rdat),
        .rd_valid_r(vld), .packet_discard_r(), .undervoltage_flag_r(),
        .summary_fault_flag_r(sff));
    asf_host_model host_u (.clk_sys(clk_sys), .req(req), .req_addr(ra),
        .rd_stb(stb), .rd_addr(addr));
    // 50 MHz
    initial forever #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] x, input logic [15:0] g);
        num_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, x, g);
        end
    endtask
    // expectation noted when the read is asked for
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        q.push_back(x);
        req <= 1'b1;
        ra <= a;
        @(posedge clk_sys);
        req <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic clr(input logic f, input logic c);
        cf <= f;
        cc <= c;
        @(posedge clk_sys);
        cf <= 1'b0;
        cc <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic results;
        n_fail += q.size();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // answers matched oldest first; cycle cap cuts a hang
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            results();
        end
        if (vld === 1'b1)
            chk(q.pop_front(), rdat);
    end
    // main sequence
    initial
    begin
        void'($urandom(76));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(16'h0001, {15'h0, sff});
        clr(1'b1, 1'b0);
        rd(ASF_OFS_FAULT, 16'h0001);
        clr(1'b1, 1'b0);
        rd(ASF_OFS_FAULT, 16'h0000);
        for (int i = 0; i < 15; i++)
        begin
            ev <= asf_event_cond_type'(15'h1 << i);
            @(posedge clk_sys);
            ev <= '0;
            e = 16'h1 << map[i][3:0];
            rd(ASF_OFS_FAULT, map[i][4] ? 16'h0800 : e);
            rd(ASF_OFS_CAUTION, map[i][4] ? e : 16'h0);
            clr(1'b1, 1'b1);
            rd(ASF_OFS_FAULT, 16'h0);
            rd(ASF_OFS_CAUTION, 16'h0);
        end
        // held undervoltage outlives a clear
        ev.analog_undervolt <= 1'b1;
        ang <= 12'($urandom);
        @(posedge clk_sys);
        rd(ASF_OFS_ANGLE, {3'b011, ~^ang, ang});
        rd(ASF_OFS_FAULT, 16'h0004);
        clr(1'b1, 1'b0);
        rd(ASF_OFS_FAULT, 16'h0004);
        fm <= '{1'b1, 1'b0, 16'h0004, 16'h0};
        @(posedge clk_sys);
        rd(ASF_OFS_ANGLE, {3'b000, ~^ang, ang});
        ev.analog_undervolt <= 1'b0;
        fm <= '0;
        clr(1'b1, 1'b0);
        rd(ASF_OFS_FAULT, 16'h0000);
        // limits crossed and bad packets
        tr <= 16'sd2000;
        gs <= 12'h005;
        rot <= -12'sd257;
        td <= -16'sd1537;
        pk <= 3'b110;
        @(posedge clk_sys);
        pk <= 3'b001;
        @(posedge clk_sys);
        pk <= '0;
        rd(ASF_OFS_TEMP, 16'h04D8);
        rd(ASF_OFS_CAUTION, 16'h0C49);
        rd(ASF_OFS_FAULT, 16'h0802);
        tr <= -16'sd700;
        gs <= 12'hF01;
        rd(ASF_OFS_TEMP, 16'h0D58);
        rd(ASF_OFS_CAUTION, 16'h0C4B);
        fm.fault_mask <= 16'h0800;
        tr <= '0;
        rot <= '0;
        td <= '0;
        gs <= 12'($urandom_range(12'hEFF, 12'h011));
        tc <= 12'($urandom);
        tsrc <= 1'($urandom);
        @(posedge clk_sys);
        rd(ASF_OFS_FAULT, 16'h0002);
        rd(ASF_OFS_FIELD, {4'h0, gs});
        rd(ASF_OFS_TURNS, {2'b00, tsrc, ~(^tc ^ tsrc), tc});
        rd(8'h30, 16'h0000);
        fm <= '0;
        clr(1'b1, 1'b1);
        rd(ASF_OFS_CAUTION, 16'h0000);
        chk(16'h0000, {15'h0, sff});
        // live status, boot and special done
        st <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
            2'b10};
        @(posedge clk_sys);
        rd(ASF_OFS_STATUS, 16'h02CD);
        rd(ASF_OFS_FAULT, 16'h0000);
        st.selftests_done <= 1'b1;
        st.special_done <= 1'b1;
        @(posedge clk_sys);
        st.special_done <= 1'b0;
        rd(ASF_OFS_STATUS, 16'h02FD);
        st.special_trigger <= 1'b1;
        @(posedge clk_sys);
        st.special_trigger <= 1'b0;
        rd(ASF_OFS_STATUS, 16'h02DD);
        // status clear drops boot done once its conditions fall
        st.selftests_done <= 1'b0;
        cs <= 1'b1;
        @(posedge clk_sys);
        cs <= 1'b0;
        rd(ASF_OFS_STATUS, 16'h02CD);
        results();
    end
endmodule
`default_nettype wire
